// ---- rtl/dpc_params.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the port controller
// Assumes: 125 MHz pclk; one port of the dual-port memory is driven
// Notes: cycle counts derive from ns figures, rounded up as least times
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// apb register byte offsets
`define DPC_OFF_CTRL 12'h000
`define DPC_OFF_CFG 12'h004
`define DPC_OFF_ADDR 12'h008
`define DPC_OFF_WDATA 12'h00C
`define DPC_OFF_RDATA 12'h010
`define DPC_OFF_STAT 12'h014

// control fields: go starts one access, wr selects write, sem selects token space
`define DPC_CTRL_GO 0
`define DPC_CTRL_WR 1
`define DPC_CTRL_SEM 2
// config fields: master strap, write inhibit driven in slave mode
`define DPC_CFG_MASTER 0
`define DPC_CFG_INHIBIT 1
`define DPC_CFG_RESET 2'b01
// status fields
`define DPC_ST_ACTIVE 0
`define DPC_ST_CONT_SEEN 1
`define DPC_ST_FLAG 2
`define DPC_ST_CONT 3
`define DPC_ST_TOKEN 4

// mailbox addresses
`define DPC_MBOX_LEFT 13'h1FFE
`define DPC_MBOX_RIGHT 13'h1FFF

// timing
`define DPC_CLK_NS 8
`define DPC_SETUP_NS 20
`define DPC_ACC_NS 25
`define DPC_REC_NS 10
`define DPC_SYNC_CYC 3
// setup also spans the pin filter, so contention is seen before any strobe starts
`define DPC_SETUP_CYC ((`DPC_SETUP_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS + `DPC_SYNC_CYC)
`define DPC_ACC_CYC ((`DPC_ACC_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS + `DPC_SYNC_CYC)
`define DPC_REC_CYC ((`DPC_REC_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)

`endif

// ---- rtl/dpc_pkg.sv ----
// Purpose: types shared by the port controller
// Assumes: 13-bit address, 18-bit data on the memory port
// Notes: constants live in dpc_params.svh
package dpc_pkg;
    typedef logic [12:0] dpc_addr_t;
    typedef logic [17:0] dpc_data_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } dpc_state_e;
endpackage

// ---- rtl/dpc_port_ctrl.sv ----
// Purpose: apb-programmed controller driving one port of a dual-port memory
// Assumes: memory pins are asynchronous to pclk and pass a three-stage filter
// Notes: one access at a time; software polls the active status bit
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "dpc_params.svh"

module dpc_port_ctrl (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory port controls
    output logic mem_enable_n,
    output logic token_select_n,
    output logic out_enable_n,
    output logic write_n,
    output dpc_pkg::dpc_addr_t mem_addr,
    output logic master_select,
    // memory data pins
    input wire dpc_pkg::dpc_data_t dq_in,
    output dpc_pkg::dpc_data_t dq_out,
    output logic dq_oe,
    // contention pin, two-way: device drives in master mode, we drive in slave mode
    input wire logic contention_n_in,
    output logic contention_n_out,
    output logic contention_oe,
    // mailbox flag of this port
    input wire logic mailbox_flag_n
);
    import dpc_pkg::*;

    localparam int PIN_W = 20;
    localparam logic [3:0] SETUP_CNT = 4'(`DPC_SETUP_CYC - 1);
    localparam logic [3:0] ACC_CNT = 4'(`DPC_ACC_CYC - 1);
    localparam logic [3:0] REC_CNT = 4'(`DPC_REC_CYC - 1);

    dpc_state_e state_r;
    logic [3:0] cnt_r;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic [PIN_W-1:0] sync3_r;
    logic [PIN_W-1:0] pin_f_r;
    logic op_wr_r;
    logic op_sem_r;
    logic cfg_master_r;
    logic cfg_inhibit_r;
    dpc_addr_t addr_r;
    dpc_data_t wdata_r;
    dpc_data_t rdata_r;
    logic cont_seen_r;
    logic apb_access;
    logic apb_wr;
    logic go_req;
    logic cont_f;
    logic flag_f;
    dpc_data_t dq_f;

    // register offset decode, used by both the write and the read path
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `DPC_OFF_CTRL) | hit(a, `DPC_OFF_CFG) | hit(a, `DPC_OFF_ADDR) |
                 hit(a, `DPC_OFF_WDATA) | hit(a, `DPC_OFF_RDATA) | hit(a, `DPC_OFF_STAT);
    endfunction

    // apb request is taken once, in the cycle before pready rises
    assign apb_access = psel && penable && !pready;
    assign apb_wr = apb_access && pwrite;
    assign go_req = apb_wr && hit(paddr, `DPC_OFF_CTRL) && pwdata[`DPC_CTRL_GO]
                    && (state_r == ST_IDLE);

    // filtered pin views
    assign pin_raw = {mailbox_flag_n, contention_n_in, dq_in};
    assign dq_f = pin_f_r[17:0];
    assign cont_f = pin_f_r[18];
    assign flag_f = pin_f_r[19];

    // three-stage pin synchroniser; a change counts once stages two and three agree
    generate
        for (genvar i = 0; i < PIN_W; i++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_r[i] <= 1'b1;
                    sync2_r[i] <= 1'b1;
                    sync3_r[i] <= 1'b1;
                    pin_f_r[i] <= 1'b1;
                end else if (clk_en) begin
                    sync1_r[i] <= pin_raw[i];
                    sync2_r[i] <= sync1_r[i];
                    sync3_r[i] <= sync2_r[i];
                    if (sync2_r[i] == sync3_r[i]) begin
                        pin_f_r[i] <= sync3_r[i];
                    end
                end
            end
        end
    endgenerate

    // apb handshake: one wait state, every register access answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= apb_access;
            pslverr <= apb_access && !mapped(paddr);
        end
    end

    // apb read data, zero outside mapped registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            prdata <= 32'h0000_0000;
            if (apb_access && !pwrite) begin
                if (hit(paddr, `DPC_OFF_CTRL)) begin
                    prdata <= {29'h0000_0000, op_sem_r, op_wr_r, 1'b0};
                end else if (hit(paddr, `DPC_OFF_CFG)) begin
                    prdata <= {30'h0000_0000, cfg_inhibit_r, cfg_master_r};
                end else if (hit(paddr, `DPC_OFF_ADDR)) begin
                    prdata <= {19'h0_0000, addr_r};
                end else if (hit(paddr, `DPC_OFF_WDATA)) begin
                    prdata <= {14'h0000, wdata_r};
                end else if (hit(paddr, `DPC_OFF_RDATA)) begin
                    prdata <= {14'h0000, rdata_r};
                end else if (hit(paddr, `DPC_OFF_STAT)) begin
                    // token bit: a token read as zero is held by this side
                    prdata <= {27'h000_0000, ~rdata_r[0], cont_f, ~flag_f, cont_seen_r,
                               state_r != ST_IDLE};
                end
            end
        end
    end

    // software-written registers; operation fields lock while an access runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_wr_r <= 1'b0;
            op_sem_r <= 1'b0;
            cfg_master_r <= 1'b1;
            cfg_inhibit_r <= 1'b0;
            addr_r <= 13'h0000;
            wdata_r <= 18'h0_0000;
        end else if (clk_en && apb_wr) begin
            if (hit(paddr, `DPC_OFF_CTRL) && state_r == ST_IDLE) begin
                op_wr_r <= pwdata[`DPC_CTRL_WR];
                op_sem_r <= pwdata[`DPC_CTRL_SEM];
            end
            if (hit(paddr, `DPC_OFF_CFG)) begin
                cfg_master_r <= pwdata[`DPC_CFG_MASTER];
                cfg_inhibit_r <= pwdata[`DPC_CFG_INHIBIT];
            end
            if (hit(paddr, `DPC_OFF_ADDR) && state_r == ST_IDLE) begin
                addr_r <= pwdata[12:0];
            end
            if (hit(paddr, `DPC_OFF_WDATA) && state_r == ST_IDLE) begin
                wdata_r <= pwdata[17:0];
            end
        end
    end

    // contention pin: slave parts take it as a write inhibit we drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_select <= 1'b1;
            contention_oe <= 1'b0;
            contention_n_out <= 1'b1;
        end else if (clk_en) begin
            master_select <= cfg_master_r;
            contention_oe <= !cfg_master_r;
            contention_n_out <= !cfg_inhibit_r;
        end
    end

    // access sequencer: setup, strobe, recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            cont_seen_r <= 1'b0;
        end else if (clk_en) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (go_req) begin
                        state_r <= ST_SETUP;
                        cnt_r <= SETUP_CNT;
                        cont_seen_r <= 1'b0;
                    end
                end
                ST_SETUP: begin
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (!op_sem_r && cfg_master_r && !cont_f) begin
                        // other side owns this location: stall until it lets go
                        cont_seen_r <= 1'b1;
                    end else begin
                        state_r <= ST_STROBE;
                        cnt_r <= ACC_CNT;
                    end
                end
                ST_STROBE: begin
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        state_r <= ST_HOLD;
                        cnt_r <= REC_CNT;
                    end
                end
                ST_HOLD: begin
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // memory port pins follow the sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_enable_n <= 1'b1;
            token_select_n <= 1'b1;
            out_enable_n <= 1'b1;
            write_n <= 1'b1;
            mem_addr <= 13'h0000;
            dq_out <= 18'h0_0000;
            dq_oe <= 1'b0;
        end else if (clk_en) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (go_req) begin
                        // token space: memory enable high, token select low
                        mem_enable_n <= pwdata[`DPC_CTRL_SEM];
                        token_select_n <= !pwdata[`DPC_CTRL_SEM];
                        mem_addr <= addr_r;
                        dq_out <= wdata_r;
                    end
                end
                ST_SETUP: begin
                    if (cnt_r == 4'h0 && (op_sem_r || !cfg_master_r || cont_f)) begin
                        write_n <= !op_wr_r;
                        out_enable_n <= op_wr_r;
                        dq_oe <= op_wr_r;
                    end
                end
                ST_STROBE: begin
                    if (cnt_r == 4'h0) begin
                        write_n <= 1'b1;
                        out_enable_n <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    dq_oe <= 1'b0;
                    if (cnt_r == 4'h0) begin
                        mem_enable_n <= 1'b1;
                        token_select_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    // read data capture at the end of the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 18'h3_FFFF;
        end else if (clk_en) begin
            if (state_r == ST_STROBE && cnt_r == 4'h0 && !op_wr_r) begin
                rdata_r <= dq_f;
            end
        end
    end
endmodule

// ---- dv/dpc_port_ctrl_assertions.sv ----
// Purpose: concurrent checks on the memory port of the controller
// Assumes: single clock, reset active low
// Notes: strobe widths follow the fixed access count
`timescale 1ns/1ps
module dpc_port_ctrl_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // memory port and contention pin
    input wire logic mem_enable_n,
    input wire logic token_select_n,
    input wire logic out_enable_n,
    input wire logic write_n,
    input wire dpc_pkg::dpc_addr_t mem_addr,
    input wire logic master_select,
    input wire logic dq_oe,
    input wire logic contention_n_in,
    input wire logic contention_oe
);
    import dpc_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // strobes held seven cycles over a steady address
    sequence s_wr_strobe;
        (!write_n && out_enable_n && $stable(mem_addr))[*7] ##1 write_n;
    endsequence
    sequence s_rd_strobe;
        (!out_enable_n && write_n && $stable(mem_addr))[*7] ##1 out_enable_n;
    endsequence
    // memory access facing a low contention pin in master mode
    sequence s_contended;
        (master_select && !mem_enable_n && !contention_n_in)[*6];
    endsequence
    a_token_excl: assert property (!token_select_n |-> mem_enable_n)
        else $error("token select with memory enable");
    a_strobe_sel: assert property ((!write_n || !out_enable_n) |-> !(mem_enable_n && token_select_n))
        else $error("strobe without a select");
    a_write_setup: assert property ($fell(write_n) |-> !($past(mem_enable_n, 3) && $past(token_select_n, 3)))
        else $error("write strobe before setup");
    a_write_width: assert property ($fell(write_n) |-> s_wr_strobe)
        else $error("write strobe width");
    a_read_width: assert property ($fell(out_enable_n) |-> s_rd_strobe)
        else $error("read strobe width");
    a_master_quiet: assert property (master_select && $past(master_select) |-> !contention_oe)
        else $error("master drives contention pin");
    a_slave_drives: assert property (!master_select && !$past(master_select) |-> contention_oe)
        else $error("slave leaves contention pin");
    a_stall_cont: assert property (s_contended |-> write_n && out_enable_n)
        else $error("strobe under contention");
    a_data_drive: assert property (!write_n |-> dq_oe)
        else $error("write strobe without data drive");
    a_read_release: assert property (!out_enable_n |-> !dq_oe)
        else $error("data driven during read");
endmodule
bind dpc_port_ctrl dpc_port_ctrl_assertions chk (.pclk(pclk), .presetn(presetn),
    .mem_enable_n(mem_enable_n), .token_select_n(token_select_n), .out_enable_n(out_enable_n),
    .write_n(write_n), .mem_addr(mem_addr), .master_select(master_select), .dq_oe(dq_oe),
    .contention_n_in(contention_n_in), .contention_oe(contention_oe));

// ---- dv/dpc_far_dev.sv ----
// Purpose: behavioural dual-port device seen from its left port
// Assumes: right port worked by bench calls; writes land at strobe end
// Notes: released data pins show the inverse of the last value
`timescale 1ns/1ps
module dpc_far_dev (
    // left port pins
    input wire logic en_n,
    input wire logic sel_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [12:0] a,
    input wire logic [17:0] d,
    input wire logic ms,
    input wire logic c_oe,
    input wire logic c_out_n,
    // pins back to the controller
    output logic [17:0] q,
    output logic cont_n,
    output logic left_mailbox_flag_n,
    output logic right_mailbox_flag_n
);
    logic [17:0] mem [0:8191];
    logic [1:0] own [0:7] = '{default: 2'd0}; // free 0, left 1, right 2
    logic [1:0] req [0:7] = '{default: 2'd0};
    logic [17:0] lat;
    logic [17:0] last = '0;
    logic r_en_n = 1'b1;
    logic [12:0] r_a = '0;
    realtime lt = 0;
    realtime rt = 0;
    // later arrival loses; pin pulled up when nobody drives
    wire busy_l = !en_n && !r_en_n && a == r_a && lt >= rt;
    wire inhib = ms ? busy_l : !cont_n;
    assign cont_n = c_oe ? c_out_n : !(ms && busy_l);
    initial begin
        left_mailbox_flag_n = 1'b1;
        right_mailbox_flag_n = 1'b1;
    end
    // token request, grant, hand-over and release
    task automatic sem_wr(input logic [1:0] s, input logic [2:0] i, input logic b);
        if (!b && own[i] == 2'd0) begin
            own[i] = s;
        end else if (own[i] != s) begin
            req[i][s - 2'd1] = !b;
        end else if (b) begin
            own[i] = req[i][2'd2 - s] ? 2'd3 - s : 2'd0;
            req[i] = 2'd0;
        end
    endtask
    function automatic logic [17:0] sem_rd(input logic [1:0] s, input logic [2:0] i);
        return {18{own[i] != s}};
    endfunction
    // right port memory accesses
    task automatic r_write(input logic [12:0] x, input logic [17:0] v);
        mem[x] = v;
        if (x == 13'h1FFE) left_mailbox_flag_n <= 1'b0;
    endtask
    function automatic logic [17:0] r_read(input logic [12:0] x);
        if (x == 13'h1FFF) right_mailbox_flag_n = 1'b1;
        return mem[x];
    endfunction
    // arrival stamps
    always @(en_n, a) lt = $realtime;
    always @(r_en_n, r_a) rt = $realtime;
    // left strobe end
    always @(posedge we_n) begin
        if (!sel_n && en_n) sem_wr(2'd1, a[2:0], d[0]);
        else if (!en_n && !inhib) begin
            mem[a] = d;
            if (a == 13'h1FFF) right_mailbox_flag_n = 1'b0;
        end
    end
    // token value latched as select and output enable go low
    always @(negedge oe_n, negedge sel_n) if (!oe_n && !sel_n) lat = sem_rd(2'd1, a[2:0]);
    // left read of its mailbox clears its flag
    always @* if (!en_n && !oe_n && a == 13'h1FFE) left_mailbox_flag_n = 1'b1;
    // read data; standby shows the inverse of the last value
    always @* begin
        if (!oe_n && !sel_n) q = lat;
        else if (!oe_n && !en_n) q = mem[a];
        else q = ~last;
    end
    always @(q) if (!oe_n) last = q;
endmodule

// ---- dv/dpc_port_ctrl_bench.sv ----
// Purpose: self-checking bench for the port controller and a model device
// Assumes: 125 MHz pclk; right port worked through the model
// Notes: token table rows first, then hand-written cases
`timescale 1ns/1ps
module dpc_port_ctrl_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, r;
    logic pready, pslverr, men_n, sel_n, oe_n, we_n, ms, dq_oe, c_out_n, c_oe, c_n, mb_n, e;
    logic [12:0] maddr;
    logic [17:0] dq_in, dq_out;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    // right-side action, written bit, left view, right view
    logic [3:0] rows [10] = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hD, 4'h7, 4'hA, 4'hF, 4'h1, 4'h7};
    always #4 pclk = ~pclk;
    dpc_port_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_enable_n(men_n), .token_select_n(sel_n),
        .out_enable_n(oe_n), .write_n(we_n), .mem_addr(maddr), .master_select(ms),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .contention_n_in(c_n),
        .contention_n_out(c_out_n), .contention_oe(c_oe), .mailbox_flag_n(mb_n));
    dpc_far_dev dev (.en_n(men_n), .sel_n(sel_n), .oe_n(oe_n), .we_n(we_n), .a(maddr),
        .d(dq_out), .ms(ms), .c_oe(c_oe), .c_out_n(c_out_n), .q(dq_in), .cont_n(c_n),
        .left_mailbox_flag_n(mb_n), .right_mailbox_flag_n());
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
        check_count++;
        if (y !== x) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, x, y);
        end
    endtask
    // one memory-port operation, polled until idle
    task automatic op(input logic [2:0] c, input logic [12:0] ad, input logic [17:0] v);
        apb(1'b1, 12'h008, {19'h0, ad});
        apb(1'b1, 12'h00C, {14'h0, v});
        apb(1'b1, 12'h000, {29'h0, c});
        r = 32'h1;
        while (r[0] !== 1'b0) apb(1'b0, 12'h014, 32'h0);
    endtask
    task automatic rst();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk("cfg", 32'h1, r);
        apb(1'b0, 12'h010, 32'h0);
        chk("rdata", 32'h3_FFFF, r);
        apb(1'b0, 12'h014, 32'h0);
        chk("status", 32'h8, r);
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // run limit
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        rst();
        for (int i = 0; i < 8; i++) chk("free", 32'h3_FFFF, {14'h0, dev.sem_rd(2'd2, i[2:0])});
        foreach (rows[k]) begin
            if (rows[k][3]) dev.sem_wr(2'd2, 3'd5, rows[k][2]);
            else op(3'b111, 13'h1FFD, {17'h0, rows[k][2]});
            op(3'b101, 13'h1FFD, 18'h0);
            apb(1'b0, 12'h010, 32'h0);
            chk("left token", {14'h0, {18{rows[k][1]}}}, r);
            apb(1'b0, 12'h014, 32'h0);
            chk("token held", {31'h0, !rows[k][1]}, {31'h0, r[4]});
            chk("right token", {14'h0, {18{rows[k][0]}}}, {14'h0, dev.sem_rd(2'd2, 3'd5)});
        end
        // mailbox both ways
        dev.r_write(13'h1FFE, 18'h1_2345);
        repeat (5) @(posedge pclk);
        apb(1'b0, 12'h014, 32'h0);
        chk("left flag", 32'h1, {31'h0, r[2]});
        op(3'b001, 13'h1FFE, 18'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("left word", 32'h1_2345, r);
        apb(1'b0, 12'h014, 32'h0);
        chk("left flag", 32'h0, {31'h0, r[2]});
        op(3'b011, 13'h1FFF, 18'h0_0ABC);
        chk("right flag", 32'h0, {31'h0, dev.right_mailbox_flag_n});
        chk("right word", 32'hABC, {14'h0, dev.r_read(13'h1FFF)});
        chk("right flag", 32'h1, {31'h0, dev.right_mailbox_flag_n});
        // master mode collision, read then write, right side first
        for (int w = 0; w < 2; w++) begin
            dev.r_write(13'h0123, 18'h0_0011);
            dev.r_a = 13'h0123;
            dev.r_en_n = 1'b0;
            fork
                op({1'b0, w[0], 1'b1}, 13'h0123, 18'h0_0055);
                begin
                    repeat (40) @(posedge pclk);
                    dev.r_en_n <= 1'b1;
                end
            join
            apb(1'b0, 12'h014, 32'h0);
            chk("stall seen", 32'h1, {31'h0, r[1]});
            chk("word", w ? 32'h55 : 32'h11, {14'h0, dev.mem[13'h0123]});
        end
        // slave mode, inhibit on then off
        for (int w = 0; w < 2; w++) begin
            apb(1'b1, 12'h004, {30'h0, !w[0], 1'b0});
            dev.r_write(13'h0040, 18'h0_0011);
            op(3'b011, 13'h0040, 18'h0_0077);
            chk("slave write", w ? 32'h77 : 32'h11, {14'h0, dev.mem[13'h0040]});
        end
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        rst();
        conclude();
    end
endmodule
